// ### include/exec_pkg.sv
// Purpose: Shared constants and types for the return/rotate/sleep executor
// Assumes: 14-bit instruction word, 13-bit program counter
// Notes: Opcode patterns follow the mid-range instruction set layout
`default_nettype none
package exec_pkg;
  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [5:0] OP_ROTL_HI = 6'h0d;
  localparam logic [5:0] OP_ROTR_HI = 6'h0c;
  localparam int DEST_BIT = 7;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
  localparam logic FLAG_N_RESET = 1'b1;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

  // Decoded operand fields of one instruction word
  typedef struct packed {
    logic dest_file;
    logic [6:0] file_addr;
  } operand_t;

  // Result of one file write request
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FLUSH = 3'b010,
    ST_SLEEP = 3'b100
  } core_state_t;
endpackage
`default_nettype wire

// ### hw/rotate_return_sleep_exec.sv
// Purpose: Executes return, rotate through carry and sleep instructions
// Assumes: Instruction and file read data valid in the same cycle
// Notes: Stack storage and wake-up logic live outside this block
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Return pops stack into PC, flags kept
// - Return takes two cycles, one flushed
// - Rotate left: carry in bit0, bit7 out
// - Rotate right: carry in bit7, bit0 out
// - Destination 0 writes W, 1 writes file
// - Sleep clears power-down, sets timeout flag
// - Sleep clears watchdog count and prescaler
// - Sleep halts execution until wake-up
module rotate_return_sleep_exec
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [7:0] file_rdata,
  input wire logic [PC_W-1:0] stack_top_value,
  input wire logic wake,
  input wire logic [7:0] watchdog_counter_in,
  input wire logic [7:0] prescale_in,
  output logic [6:0] file_raddr,
  output logic stack_pop,
  output logic insn_ready,
  output logic flush,
  output file_wr_t file_wr_r,
  output logic [7:0] w_r,
  output logic carry_r,
  output logic [PC_W-1:0] pc_r,
  output logic pc_load_r,
  output logic power_down_flag_n,
  output logic timeout_flag_n,
  output logic [7:0] watchdog_counter,
  output logic [7:0] prescale_r,
  output logic osc_halt
);

  // ****************************************
  // Decode
  // ****************************************
  core_state_t state_r;
  core_state_t state_nxt;
  operand_t opnd;
  logic exec;
  logic is_ret;
  logic is_slp;
  logic is_rot_l;
  logic is_rot_r;
  logic [7:0] rot_res;
  logic rot_c;
  logic power_down_r;
  logic timeout_r;
  logic [7:0] watchdog_r;

  // Matches a rotate opcode family by its top six bits
  function automatic logic op_hi_match(input logic [INSN_W-1:0] w, input logic [5:0] hi);
    op_hi_match = (w[13:8] == hi);
  endfunction

  assign opnd = operand_t'(insn[7:0]);
  assign insn_ready = (state_r == ST_RUN);
  assign exec = insn_valid && insn_ready;
  assign is_ret = exec && (insn == OP_RETURN);
  assign is_slp = exec && (insn == OP_SLEEP);
  assign is_rot_l = exec && op_hi_match(insn, OP_ROTL_HI);
  assign is_rot_r = exec && op_hi_match(insn, OP_ROTR_HI);
  assign file_raddr = opnd.file_addr;
  assign stack_pop = is_ret;
  assign flush = (state_r == ST_FLUSH);
  assign osc_halt = (state_r == ST_SLEEP);

  // Rotate datapath through the carry
  always_comb begin
    rot_res = file_rdata;
    rot_c = carry_r;
    if (is_rot_l) begin
      rot_res = {file_rdata[6:0], carry_r};
      rot_c = file_rdata[7];
    end else if (is_rot_r) begin
      rot_res = {carry_r, file_rdata[7:1]};
      rot_c = file_rdata[0];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Sleep ignores instruction fetch entirely; only wake leaves it
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (is_ret) begin
          state_nxt = ST_FLUSH;
        end else if (is_slp) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_FLUSH: begin
        state_nxt = ST_RUN;
      end
      ST_SLEEP: begin
        if (wake) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Program counter load from stack; status flags untouched here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= PC_RESET;
      pc_load_r <= 1'b0;
    end else begin
      pc_load_r <= is_ret;
      if (is_ret) begin
        pc_r <= stack_top_value;
      end
    end
  end

  // Rotate results: carry only flag touched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_r <= 1'b0;
      w_r <= 8'h00;
      file_wr_r <= '0;
    end else begin
      file_wr_r.en <= 1'b0;
      if (is_rot_l || is_rot_r) begin
        carry_r <= rot_c;
        if (opnd.dest_file) begin
          file_wr_r.en <= 1'b1;
          file_wr_r.addr <= opnd.file_addr;
          file_wr_r.data <= rot_res;
        end else begin
          w_r <= rot_res;
        end
      end
    end
  end

  // Sleep status bits; they hold until reset restores them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_down_r <= FLAG_N_RESET;
      timeout_r <= FLAG_N_RESET;
    end else if (is_slp) begin
      power_down_r <= 1'b0;
      timeout_r <= 1'b1;
    end
  end

  // Watchdog and prescaler mirror their inputs except on sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_r <= WATCHDOG_CLEAR;
      prescale_r <= PRESCALE_CLEAR;
    end else if (is_slp) begin
      watchdog_r <= WATCHDOG_CLEAR;
      prescale_r <= PRESCALE_CLEAR;
    end else begin
      watchdog_r <= watchdog_counter_in;
      prescale_r <= prescale_in;
    end
  end

  assign power_down_flag_n = power_down_r;
  assign timeout_flag_n = timeout_r;
  assign watchdog_counter = watchdog_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_ret_pc;
    @(posedge clk) disable iff (rst)
    is_ret |=> (pc_r == $past(stack_top_value)) && pc_load_r;
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return did not load pc");

  property p_ret_flags;
    @(posedge clk) disable iff (rst)
    is_ret |=> $stable(carry_r) && $stable(power_down_r);
  endproperty
  a_ret_flags: assert property (p_ret_flags) else $error("return changed a flag");

  property p_ret_two;
    @(posedge clk) disable iff (rst)
    is_ret |=> flush && !insn_ready ##1 insn_ready;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_rot_left;
    @(posedge clk) disable iff (rst)
    is_rot_l && !opnd.dest_file |=>
      w_r == {$past(file_rdata[6:0]), $past(carry_r)} && carry_r == $past(file_rdata[7]);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_rot_right;
    @(posedge clk) disable iff (rst)
    is_rot_r && !opnd.dest_file |=>
      w_r == {$past(carry_r), $past(file_rdata[7:1])} && carry_r == $past(file_rdata[0]);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_dest_file;
    @(posedge clk) disable iff (rst)
    (is_rot_l || is_rot_r) && opnd.dest_file |=>
      file_wr_r.en && file_wr_r.addr == $past(opnd.file_addr) && $stable(w_r);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_sleep_flags;
    @(posedge clk) disable iff (rst)
    is_slp |=> !power_down_flag_n && timeout_flag_n;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

  property p_sleep_watchdog;
    @(posedge clk) disable iff (rst)
    is_slp |=> watchdog_counter == WATCHDOG_CLEAR && prescale_r == PRESCALE_CLEAR;
  endproperty
  a_sleep_watchdog: assert property (p_sleep_watchdog) else $error("watchdog not cleared");

  property p_sleep_halt;
    @(posedge clk) disable iff (rst)
    is_slp ##1 !wake |=> osc_halt && !insn_ready;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sleep did not halt");

  c_ret: cover property (@(posedge clk) disable iff (rst) is_ret ##2 exec);
  c_rot_file: cover property (@(posedge clk) disable iff (rst) is_rot_l && opnd.dest_file);
  c_rot_right_w: cover property (@(posedge clk) disable iff (rst) is_rot_r && !opnd.dest_file);
  c_sleep_wake: cover property (@(posedge clk) disable iff (rst) is_slp ##[1:20] wake);

endmodule
`default_nettype wire

// ### bench/rotate_return_sleep_exec_bench.sv
// Purpose: Self-checking bench for the return, rotate and sleep executor
// Assumes: Inputs driven at the falling edge, outputs checked there too
// Notes: Rotates run back to back so the carry chain is exercised
`timescale 1ns/1ps
`default_nettype none
module rotate_return_sleep_exec_bench;
  import exec_pkg::*;
  // ****************************************
  // Stimulus signals and model state
  // ****************************************
  logic clk = 0, rst = 1, insn_valid = 0, wake = 0;
  logic [INSN_W-1:0] insn = '0;
  logic [7:0] file_rdata = '0, wd_in = '0, pre_in = '0;
  logic [PC_W-1:0] stk = '0;
  logic [6:0] file_raddr;
  logic stack_pop, insn_ready, flush, carry_r, pc_load_r, pwr_down_n, tmo_n, osc_halt;
  file_wr_t file_wr_r, ewr;
  logic [7:0] w_r, wd, prescale_r, f, res;
  logic [PC_W-1:0] pc_r;
  logic [6:0] a;
  logic d, mc = 0;
  logic [7:0] mw = '0;
  int fail_count = 0, num_checks = 0;
  rotate_return_sleep_exec uut (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .file_rdata(file_rdata), .stack_top_value(stk), .wake(wake),
    .watchdog_counter_in(wd_in), .prescale_in(pre_in), .file_raddr(file_raddr),
    .stack_pop(stack_pop), .insn_ready(insn_ready), .flush(flush), .file_wr_r(file_wr_r),
    .w_r(w_r), .carry_r(carry_r), .pc_r(pc_r), .pc_load_r(pc_load_r),
    .power_down_flag_n(pwr_down_n), .timeout_flag_n(tmo_n), .watchdog_counter(wd),
    .prescale_r(prescale_r), .osc_halt(osc_halt));
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Compare the last rotate against the model
  task automatic check_rot();
    check("carry", carry_r, mc);
    check("w", w_r, mw);
    check("wr_en", file_wr_r.en, ewr.en);
    if (ewr.en) check("wr", file_wr_r, ewr);
  endtask
  // Hang guard: a run past its budget counts as a mismatch
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h637c));
    repeat (12) @(negedge clk);
    check("flags", {pwr_down_n, tmo_n, carry_r}, 3'b110);
    check("regs", {w_r, wd}, 16'h0000);
    rst = 0;
    // Back-to-back rotates, both directions and destinations
    for (int i = 0; i < 40; i++) begin
      f = 8'($urandom);
      d = 1'($urandom);
      a = (i == 1) ? 7'h7f : 7'($urandom);
      @(negedge clk);
      if (i > 0) check_rot();
      insn_valid = 1;
      insn = {i[1] ? OP_ROTL_HI : OP_ROTR_HI, d, a};
      file_rdata = f;
      res = i[1] ? {f[6:0], mc} : {mc, f[7:1]};
      mc = i[1] ? f[7] : f[0];
      if (!d) mw = res;
      ewr = '{en: d, addr: a, data: res};
      #1 check("raddr", file_raddr, a);
    end
    // Return: pop, then one discarded cycle even with a second return held
    @(negedge clk);
    check_rot();
    insn = OP_RETURN;
    stk = 13'($urandom);
    #1 check("pop", stack_pop, 1'b1);
    @(negedge clk);
    check("pc", {pc_load_r, pc_r}, {1'b1, stk});
    check("flush", {flush, insn_ready, stack_pop}, 3'b100);
    check("keep", {carry_r, w_r}, {mc, mw});
    @(negedge clk);
    check("after", {pc_load_r, insn_ready, pc_r}, {2'b01, stk});
    // Sleep with nonzero counts; a held rotate must not run while asleep
    wd_in = 8'($urandom) | 8'h01;
    pre_in = 8'($urandom) | 8'h80;
    insn = OP_SLEEP;
    @(negedge clk);
    insn = {OP_ROTL_HI, 1'b1, 7'h05};
    check("cnt", {wd, prescale_r}, {WATCHDOG_CLEAR, PRESCALE_CLEAR});
    repeat (3) begin
      check("st", {pwr_down_n, tmo_n, osc_halt, insn_ready}, 4'h6);
      check("halt", {file_wr_r.en, carry_r}, {1'b0, mc});
      @(negedge clk);
      // Counts pass through again once the sleep edge is over
      check("cnt", {wd, prescale_r}, {wd_in, pre_in});
    end
    wake = 1;
    @(negedge clk);
    wake = 0;
    insn_valid = 0;
    check("woke", {insn_ready, osc_halt}, 2'b10);
    @(negedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
